//--- shared/spper_pkg.sv
package spper_pkg;

  // ==========================================================================
  // port layout
  localparam int NUM_PORTS = 3;
  localparam int VPHY_PORT = 0;

  // ==========================================================================
  // register map: one manual pause register per port, one word apart
  localparam int REG_IDX_LSB = 2;
  localparam int REG_IDX_W = 2;
  localparam int MANUAL_W = 4;

  // field positions inside a manual pause register
  localparam int FLD_SEL = 0;
  localparam int FLD_BP = 1;
  localparam int FLD_TX = 2;
  localparam int FLD_RX = 3;
  localparam int FLD_FULL = 8;
  localparam int FLD_TXEN = 9;
  localparam int FLD_RXEN = 10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic an_enable;
    logic an_complete;
    logic lp_an_able;
    logic full_duplex;
    logic adv_pause;
    logic adv_asym;
    logic lp_pause;
    logic lp_asym;
  } spper_phy_s;

  // bit order matches FLD_SEL..FLD_RX
  typedef struct packed {
    logic manual_rx_pause_bit;
    logic manual_tx_pause_bit;
    logic backpressure_enable_bit;
    logic manual_pause_select;
  } spper_manual_s;

  localparam spper_manual_s MANUAL_RST = 4'h0;

  typedef struct packed {
    logic full_duplex;
    logic tx_en;
    logic rx_en;
    logic backpressure_en;
    logic pause_send_en;
    logic pause_honor_en;
  } spper_fc_s;

endpackage

//--- logic/spper_resolver.sv
`timescale 1ns/1ps
`default_nettype none

module spper_resolver (
  input wire logic aclk,
  input wire logic aresetn,
  input wire spper_pkg::spper_phy_s phy,
  input wire spper_pkg::spper_manual_s manual,
  output var spper_pkg::spper_fc_s fc
);
  import spper_pkg::*;

  typedef struct packed {
    spper_fc_s fc;
  } spper_res_state_s;

  spper_res_state_s st_r;
  spper_res_state_s st_nxt;
  logic tx;
  logic rx;
  logic full;

  // ==========================================================================
  // enable resolution
  always_comb
  begin
    st_nxt = st_r;
    tx = 1'b0;
    rx = 1'b0;
    full = phy.full_duplex;
    if (!phy.an_enable || manual.manual_pause_select)
    begin
      if (phy.full_duplex)
      begin
        rx = manual.manual_rx_pause_bit;
        tx = manual.manual_tx_pause_bit;
      end
      else
      begin
        tx = manual.backpressure_enable_bit;
      end
    end
    else if (!phy.an_complete)
    begin
      // result not settled yet: both held off
      tx = 1'b0;
    end
    else if (!phy.lp_an_able || !phy.full_duplex)
    begin
      // parallel detect forces half duplex
      full = 1'b0;
      tx = manual.backpressure_enable_bit;
    end
    else
    begin
      if (phy.adv_pause && phy.lp_pause)
      begin
        rx = 1'b1;
        tx = 1'b1;
      end
      else if (!phy.adv_pause && phy.adv_asym && phy.lp_pause && phy.lp_asym)
      begin
        tx = 1'b1;
      end
      else if (phy.adv_pause && phy.adv_asym && !phy.lp_pause && phy.lp_asym)
      begin
        rx = 1'b1;
      end
      // everything else leaves both at zero
    end
    st_nxt.fc.full_duplex = full;
    st_nxt.fc.tx_en = tx;
    st_nxt.fc.rx_en = rx;
    st_nxt.fc.backpressure_en = tx && !full;
    st_nxt.fc.pause_send_en = tx && full;
    st_nxt.fc.pause_honor_en = rx;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign fc = st_r.fc;

endmodule

`default_nettype wire

//--- logic/spper_top.sv
// Contract
// - each of ports 0..2 has its own transmit and receive pause enable
// - transmit enable means back pressure in half duplex, pause frames in full
// - receive enable decides whether received pause frames stop transmission
// - port 0 uses virtual phy, port 1 phy a, port 2 phy b status
// - half duplex: receive enable 0, transmit enable follows back pressure bit
// - full duplex, negotiation off or manual select: enables follow manual bits
// - full duplex, negotiation on, select clear: enables come from negotiation
// - manual bits never alter the phy advertisement pause bits
// - negotiation on, select clear, not complete: both enables held at 0
// - partner cannot negotiate: treat as half duplex, back pressure bit drives tx
// - negotiated full duplex follows the standard pause resolution table
// - both symmetric pause bits set: both enables 1
// - local 0/1, partner 1/1: transmit 1, receive 0
// - local 1/1, partner 0/1: receive 1, transmit 0
// - any other negotiated full duplex combination: both enables 0
// - virtual phy port swaps local and partner pause bits
// - manual register reads back duplex and enables in effect
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module spper_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire spper_pkg::spper_phy_s [spper_pkg::NUM_PORTS-1:0] phy_status,
  output var spper_pkg::spper_fc_s [spper_pkg::NUM_PORTS-1:0] port_fc
);
  import spper_pkg::*;

  // ==========================================================================
  // elaboration checks
  if (ADDR_W < REG_IDX_LSB + REG_IDX_W + 1 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("spper_top: ADDR_W out of range");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    spper_phy_s [NUM_PORTS-1:0] meta;
    spper_phy_s [NUM_PORTS-1:0] sync;
    spper_manual_s [NUM_PORTS-1:0] manual;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spper_top_state_s;

  localparam spper_top_state_s ST_RST = '{
    manual: {NUM_PORTS{MANUAL_RST}},
    default: '0
  };

  spper_top_state_s st_r;
  spper_top_state_s st_nxt;
  spper_phy_s [NUM_PORTS-1:0] loc;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic [REG_IDX_W-1:0] wr_idx;
  logic wr_hit;
  logic [REG_IDX_W-1:0] rd_idx;
  logic rd_hit;

  // ==========================================================================
  // address decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    logic upper_zero;
    logic [REG_IDX_W-1:0] idx;
    upper_zero = (addr >> (REG_IDX_LSB + REG_IDX_W)) == '0;
    idx = addr[REG_IDX_LSB +: REG_IDX_W];
    return upper_zero && (int'(idx) < NUM_PORTS);
  endfunction

  assign wr_idx = st_r.awaddr[REG_IDX_LSB +: REG_IDX_W];
  assign wr_hit = reg_hit(st_r.awaddr);
  assign rd_idx = araddr[REG_IDX_LSB +: REG_IDX_W];
  assign rd_hit = reg_hit(araddr);

  // ==========================================================================
  // bus handshakes
  // address and data are held separately so they may arrive in any order
  assign awready = !st_r.aw_have && !st_r.bvalid;
  assign wready = !st_r.w_have && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign aw_fire = awvalid && awready;
  assign w_fire = wvalid && wready;
  assign ar_fire = arvalid && arready;

  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  // ==========================================================================
  // phy role mapping
  for (genvar i = 0; i < NUM_PORTS; i++)
  begin : g_role
    if (i == VPHY_PORT)
    begin : g_swap
      // virtual phy reports from the host's side, so roles are crossed;
      // a continuous assign like the other ports keeps loc one kind of driver
      assign loc[i] = {
        st_r.sync[i].an_enable,
        st_r.sync[i].an_complete,
        st_r.sync[i].lp_an_able,
        st_r.sync[i].full_duplex,
        st_r.sync[i].lp_pause,
        st_r.sync[i].lp_asym,
        st_r.sync[i].adv_pause,
        st_r.sync[i].adv_asym
      };
    end
    else
    begin : g_direct
      assign loc[i] = st_r.sync[i];
    end
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // status pins come from the phy domains: two flops before any use
    st_nxt.meta = phy_status;
    st_nxt.sync = st_r.meta;

    if (st_r.bvalid && bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (aw_fire)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = awaddr;
    end
    if (w_fire)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = wdata;
      st_nxt.wstrb = wstrb;
    end
    if (st_r.aw_have && st_r.w_have)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      // only the low byte holds writable bits; the phy advertisement
      // is never touched from here
      if (wr_hit && st_r.wstrb[0])
      begin
        st_nxt.manual[wr_idx] = spper_manual_s'(st_r.wdata[MANUAL_W-1:0]);
      end
    end

    if (st_r.rvalid && rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_fire)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = '0;
      st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (rd_hit)
      begin
        st_nxt.rdata[MANUAL_W-1:0] = st_r.manual[rd_idx];
        st_nxt.rdata[FLD_FULL] = port_fc[rd_idx].full_duplex;
        st_nxt.rdata[FLD_TXEN] = port_fc[rd_idx].tx_en;
        st_nxt.rdata[FLD_RXEN] = port_fc[rd_idx].rx_en;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // per-port resolvers
  for (genvar i = 0; i < NUM_PORTS; i++)
  begin : g_port
    spper_resolver u_res (
      .aclk(aclk),
      .aresetn(aresetn),
      .phy(loc[i]),
      .manual(st_r.manual[i]),
      .fc(port_fc[i])
    );
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  for (genvar i = 0; i < NUM_PORTS; i++)
  begin : g_chk
    logic forced;
    logic neg_ok;
    assign forced = !loc[i].an_enable || st_r.manual[i].manual_pause_select;
    assign neg_ok = loc[i].an_enable && !st_r.manual[i].manual_pause_select
      && loc[i].an_complete;

    sequence s_neg_full;
      neg_ok && loc[i].lp_an_able && loc[i].full_duplex;
    endsequence

    sequence s_half_settled;
      !loc[i].full_duplex && (forced || neg_ok);
    endsequence

    a_half_duplex_bp: assert property (
      s_half_settled |=> !port_fc[i].rx_en
        && port_fc[i].tx_en == $past(st_r.manual[i].backpressure_enable_bit)
        && port_fc[i].backpressure_en == port_fc[i].tx_en)
      else $error("half duplex enables wrong");

    a_manual_full: assert property (
      forced && loc[i].full_duplex |=>
        port_fc[i].tx_en == $past(st_r.manual[i].manual_tx_pause_bit)
        && port_fc[i].rx_en == $past(st_r.manual[i].manual_rx_pause_bit)
        && port_fc[i].pause_send_en == port_fc[i].tx_en)
      else $error("manual full duplex enables wrong");

    a_an_pending_off: assert property (
      loc[i].an_enable && !st_r.manual[i].manual_pause_select
        && !loc[i].an_complete |=> !port_fc[i].tx_en && !port_fc[i].rx_en)
      else $error("enables on while negotiating");

    a_lp_not_able: assert property (
      neg_ok && !loc[i].lp_an_able |=> !port_fc[i].full_duplex && !port_fc[i].rx_en
        && port_fc[i].tx_en == $past(st_r.manual[i].backpressure_enable_bit))
      else $error("parallel detect not treated as half duplex");

    a_sym_pause: assert property (
      s_neg_full ##0 (loc[i].adv_pause && loc[i].lp_pause) |=>
        port_fc[i].tx_en && port_fc[i].rx_en)
      else $error("symmetric pause not enabled");

    a_asym_toward_lp: assert property (
      s_neg_full ##0 (loc[i] [3:0] == 4'h7) |=> port_fc[i].tx_en && !port_fc[i].rx_en)
      else $error("asymmetric pause toward partner wrong");

    a_asym_from_lp: assert property (
      s_neg_full ##0 (loc[i] [3:0] == 4'hd) |=> !port_fc[i].tx_en && port_fc[i].rx_en)
      else $error("asymmetric pause from partner wrong");

    a_other_pause_off: assert property (
      s_neg_full ##0 !(loc[i].adv_pause && loc[i].lp_pause)
        ##0 (loc[i] [3:0] != 4'h7) ##0 (loc[i] [3:0] != 4'hd)
        |=> !port_fc[i].tx_en && !port_fc[i].rx_en)
      else $error("pause enabled for unsupported combination");

    a_pin_to_output: assert property (
      $stable(phy_status[i]) [*3] ##0 $stable(st_r.manual[i]) [*2]
        |=> $stable(port_fc[i]))
      else $error("enables changed with stable inputs");
  end

  a_readback_state: assert property (
    ar_fire && rd_hit |=> rvalid
      && rdata[FLD_TXEN] == $past(port_fc[rd_idx].tx_en)
      && rdata[FLD_RXEN] == $past(port_fc[rd_idx].rx_en)
      && rdata[FLD_FULL] == $past(port_fc[rd_idx].full_duplex))
    else $error("readback does not show enables in effect");

endmodule

`default_nettype wire

//--- verif/spper_phy_model.sv
`timescale 1ns/1ps
`default_nettype none

module spper_phy_model (
  input wire logic aclk,
  output var spper_pkg::spper_phy_s [spper_pkg::NUM_PORTS-1:0] phy_status
);
  import spper_pkg::*;

  // ==========================================================================
  // phy status levels
  // index 0 virtual phy, 1 phy a, 2 phy b
  spper_phy_s [NUM_PORTS-1:0] st_r = '0;
  // advertisement bits live only here; the block has no path to write them
  assign phy_status = st_r;

  // status moves only just after an edge, as the phy's own registers do
  task automatic set_port(input int p, input spper_phy_s v);
    @(posedge aclk);
    st_r[p] <= v;
  endtask
endmodule

`default_nettype wire

//--- verif/spper_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spper_top_tb;
  import spper_pkg::*;

  // ==========================================================================
  // signals
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0;
  logic awready;
  logic [7:0] awaddr = '0;
  logic wvalid = 0;
  logic wready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic bvalid;
  logic bready = 0;
  logic [1:0] bresp;
  logic arvalid = 0;
  logic arready;
  logic [7:0] araddr = '0;
  logic rvalid;
  logic rready = 0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  spper_phy_s [NUM_PORTS-1:0] phy_status;
  spper_fc_s [NUM_PORTS-1:0] port_fc;
  spper_fc_s [NUM_PORTS-1:0] e = '0;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int p;
  logic [14:0] v;
  logic [1:0] r;
  logic [31:0] d;

  // rows: phy status, manual bits, expected {full, tx, rx}
  localparam logic [14:0] ROWS [16] = '{
    {8'hef, 4'h3, 3'h2},
    {8'h6f, 4'h2, 3'h2},
    {8'hf0, 4'h9, 3'h5},
    {8'h10, 4'h4, 3'h6},
    {8'h8f, 4'he, 3'h0},
    {8'hdf, 4'h2, 3'h2},
    {8'hef, 4'hc, 3'h0},
    {8'hf3, 4'hc, 3'h4},
    {8'hf5, 4'hc, 3'h4},
    {8'hf6, 4'hc, 3'h4},
    {8'hf7, 4'hc, 3'h6},
    {8'hf9, 4'hc, 3'h4},
    {8'hfa, 4'hc, 3'h7},
    {8'hff, 4'hc, 3'h7},
    {8'hfc, 4'hc, 3'h4},
    {8'hfd, 4'hc, 3'h5}
  };

  spper_top #(.ADDR_W(8)) dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .awprot(3'h0),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .arprot(3'h0),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .phy_status(phy_status),
    .port_fc(port_fc)
  );

  spper_phy_model m (
    .aclk(aclk),
    .phy_status(phy_status)
  );

  initial
  begin
    forever #4 aclk = ~aclk;
  end

  // ==========================================================================
  // helpers
  function automatic spper_fc_s mk(input logic [2:0] x);
    mk = {x[2], x[1], x[0], x[1] & ~x[2], x[1] & x[2], x[0]};
  endfunction

  // the virtual phy reports its own view, so local and partner trade places
  function automatic logic [7:0] sw(input logic [7:0] x);
    sw = {x[7:4], x[1:0], x[3:2]};
  endfunction

  task automatic chk_w(input string n, input logic [31:0] ex, input logic [31:0] g);
    compares++;
    if (g !== ex)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, ex, g);
    end
  endtask

  task automatic chk_fc(input string n, input spper_fc_s ex, input spper_fc_s g);
    compares++;
    if (g !== ex)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, ex, g);
    end
  endtask

  // ready is a comb level that moves only on edges, so the negedge sees what the edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s,
                    output logic [1:0] rs);
    logic ha;
    logic hw;
    logic ta;
    logic tw;
    ha = 1;
    hw = 1;
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= dv;
    wstrb <= s;
    bready <= 1;
    while (ha || hw)
    begin
      @(negedge aclk);
      ta = ha && awready;
      tw = hw && wready;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      ha = ha && !ta;
      hw = hw && !tw;
    end
    @(negedge aclk);
    while (!bvalid) @(negedge aclk);
    rs = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    dv = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask

  task automatic complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      complete_run;
    end
  end

  // ==========================================================================
  // sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 16; i++)
    begin
      p = i % 3;
      v = ROWS[i];
      m.set_port(p, p == 0 ? sw(v[14:7]) : v[14:7]);
      wr(8'(p * 4), {28'h0, v[6:3]}, 4'h1, r);
      chk_w("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      e[p] = mk(v[2:0]);
      for (int q = 0; q < NUM_PORTS; q++)
        chk_fc("port_fc", e[q], port_fc[q]);
      rd(8'(p * 4), d, r);
      chk_w("readback", {21'h0, v[0], v[1], v[2], 4'h0, v[6:3]}, d);
    end
    // status change lands exactly three edges later
    m.set_port(2, 8'hfa);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_fc("fc_early", e[2], port_fc[2]);
    @(posedge aclk);
    @(negedge aclk);
    chk_fc("fc_sync", mk(3'h7), port_fc[2]);
    // manual register moves at the edge that raises bvalid; enables follow one edge later,
    // which is the edge that the write task ends on, so the hold is watched alongside it
    fork
      wr(8'h08, 32'h9, 4'h1, r);
      begin
        @(negedge aclk);
        while (!bvalid) @(negedge aclk);
        chk_fc("fc_hold", mk(3'h7), port_fc[2]);
      end
    join
    @(negedge aclk);
    chk_fc("fc_manual", mk(3'h5), port_fc[2]);
    wr(8'h08, 32'h0, 4'h0, r);
    chk_w("strb_resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(8'h08, d, r);
    chk_w("strb_keep", 32'h509, d);
    foreach (ROWS[k])
    begin
      if (k < 2)
      begin
        wr(k == 0 ? 8'h0c : 8'h40, 32'hf, 4'hf, r);
        chk_w("bad_wresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(k == 0 ? 8'h0c : 8'h40, d, r);
        chk_w("bad_rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk_w("bad_rdata", 32'h0, d);
      end
    end
    // second reset: manual bits clear and every enable drops
    for (int q = 0; q < NUM_PORTS; q++)
      m.set_port(q, 8'h00);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    for (int q = 0; q < NUM_PORTS; q++)
    begin
      chk_fc("fc_reset", '0, port_fc[q]);
      rd(8'(q * 4), d, r);
      chk_w("reg_reset", 32'h0, d);
    end
    complete_run;
  end
endmodule

`default_nettype wire
